// >>> clra_pkg.sv
// Shared constants for the display controller RAM access path.
package clra_pkg;
   // ==========================================================================
   // Bus and instruction encoding
   // ==========================================================================
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned AC_W         = 7;
   localparam int unsigned BIT_BUSY     = 7;
   localparam int unsigned BIT_DDR_SET  = 7;
   localparam int unsigned BIT_CGR_SET  = 6;
   localparam int unsigned BIT_FUNC     = 5;
   localparam int unsigned BIT_WIDTH    = 4;
   localparam int unsigned BIT_LINES    = 3;
   localparam int unsigned BIT_FONT     = 2;
   localparam int unsigned BIT_SHIFT    = 4;
   localparam int unsigned BIT_SC       = 3;
   localparam int unsigned BIT_RL       = 2;
   localparam int unsigned BIT_ENTRY    = 2;
   localparam int unsigned BIT_INCDEC   = 1;
   localparam int unsigned BIT_CLEAR    = 0;
   localparam int unsigned BIT_HOME     = 1;
   localparam int unsigned BIT_DISP     = 3;
   // ==========================================================================
   // Address map
   // ==========================================================================
   localparam logic [6:0] DD_ONE_LAST   = 7'h4f;
   localparam logic [6:0] DD_L1_LAST    = 7'h27;
   localparam logic [6:0] DD_L2_FIRST   = 7'h40;
   localparam logic [6:0] DD_L2_LAST    = 7'h67;
   localparam logic [6:0] CG_MASK       = 7'h3f;
   // ==========================================================================
   // Reset values and timing
   // ==========================================================================
   localparam logic       RST_WIDTH8    = 1'b1;
   localparam logic       RST_TWO_LINE  = 1'b0;
   localparam logic       RST_FONT_BIG  = 1'b0;
   localparam logic       RST_INC       = 1'b1;
   localparam int unsigned CLK_MHZ      = 25;
   localparam int unsigned EXEC_NS      = 200;
   localparam int unsigned EXEC_CYC     = (EXEC_NS * CLK_MHZ) / 1000;
endpackage : clra_pkg

// >>> clra_if.sv
// Parallel host bus between the controller and the display device.
`timescale 1ns/1ps
`default_nettype none
interface clra_if;
   logic       reg_select;   // Low selects instructions, high selects data.
   logic       rd_wr;        // High reads, low writes.
   logic       strobe;       // One-cycle enable pulse for a transfer.
   logic [7:0] bus_host;     // Data driven by the host.
   logic       bus_host_oe;  // Host drives the data bus.
   logic [7:0] bus_dev;      // Data driven by the device.
   logic       bus_dev_oe;   // Device drives the data bus.
   logic [7:0] bus_wire;
   assign bus_wire = bus_host_oe ? bus_host : (bus_dev_oe ? bus_dev : 8'hff);
   modport host (output reg_select, rd_wr, strobe, bus_host, bus_host_oe,
                 input bus_wire);
   modport dev  (input reg_select, rd_wr, strobe, bus_wire,
                 output bus_dev, bus_dev_oe);
endinterface : clra_if
`default_nettype wire

// >>> clra_addr_step.sv
// Address counter stepping and wrap within the selected RAM window.
`timescale 1ns/1ps
`default_nettype none
module clra_addr_step
   import clra_pkg::*;
(
   input  wire logic [6:0] addr_in,      // Current address counter.
   input  wire logic       inc_in,       // High steps up, low steps down.
   input  wire logic       glyph_in,     // Glyph RAM is selected.
   input  wire logic       two_line_in,  // Two-line display map.
   output logic      [6:0] addr_out      // Stepped address.
);
   always_comb
   begin
      if (glyph_in)
         addr_out = (inc_in ? addr_in + 7'h01 : addr_in - 7'h01) & CG_MASK;
      else if (!two_line_in)
      begin
         if (inc_in)
            addr_out = (addr_in >= DD_ONE_LAST) ? 7'h00 : addr_in + 7'h01;
         else
            addr_out = (addr_in == 7'h00) ? DD_ONE_LAST : addr_in - 7'h01;
      end
      else if (inc_in)
      begin
         if (addr_in == DD_L1_LAST)
            addr_out = DD_L2_FIRST;
         else if (addr_in >= DD_L2_LAST)
            addr_out = 7'h00;
         else
            addr_out = addr_in + 7'h01;
      end
      else
      begin
         if (addr_in == DD_L2_FIRST)
            addr_out = DD_L1_LAST;
         else if (addr_in == 7'h00)
            addr_out = DD_L2_LAST;
         else
            addr_out = addr_in - 7'h01;
      end
   end
endmodule : clra_addr_step
`default_nettype wire

// >>> clra_device.sv
// Display device end: instruction decode, RAM access and busy indicator.
//
// Overview of operation
// - Line-count bit low one line, high two.
// - Font bit low 5x8, high 5x11 dots.
// - Glyph address set loads six counter bits.
// - Display address set loads seven counter bits.
// - One-line display addresses run 00H to 4FH.
// - Two-line map 00H-27H then 40H-67H.
// - Status read returns busy and address counter.
// - Host waits until busy indicator reads low.
// - Data write stores byte at counter address.
// - Latest address set selects the RAM; clear and return home also select display RAM here.
// - Counter steps by one after each write.
// - Data read returns output data register.
// - First read without address set invalid.
// - Cursor shift with display RAM selected reloads output data register.
// - Counter steps by one after each read.
// - Host avoids display shift after glyph read.
// - Read after write returns stale data.
// - Increment bit high increases address by one.
// - Width bit high eight, low four bits.
// - Four-bit mode sends each byte twice.
`timescale 1ns/1ps
`default_nettype none
module clra_device
   import clra_pkg::*;
#(
   parameter int unsigned EXEC_CYCLES = EXEC_CYC
)(
   input  wire logic clk_in,        // 25 MHz clock.
   input  wire logic rst_n_in,      // Asynchronous reset, active low.
   clra_if.dev       bus,           // Host bus.
   output logic      two_line_out,  // Two-line display mode.
   output logic      font_big_out,  // 5x11 dot font selected.
   output logic      width8_out,    // Eight-bit bus mode.
   output logic      glyph_sel_out  // Glyph RAM selected for data.
);
   typedef enum logic [1:0] {
      CLRA_IDLE = 2'b01,
      CLRA_EXEC = 2'b10
   } clra_dev_state_e;

   clra_dev_state_e state_reg;
   logic [7:0]  display_ram [0:127];
   logic [7:0]  glyph_ram   [0:63];
   logic [6:0]  addr_counter_reg;
   logic [6:0]  addr_step;
   logic [7:0]  out_data_reg;
   logic        inc_reg;
   logic        nibble_hi_reg;
   logic [3:0]  nib_reg;
   logic [15:0] exec_cnt_reg;
   logic        busy_indicator;
   logic        rs_wr_take;
   logic [7:0]  byte_in;
   logic        take;
   logic        is_read;
   logic [6:0]  shift_step;

   // ==========================================================================
   // Nibble assembly
   // ==========================================================================
   assign byte_in = width8_out ? bus.bus_wire : {nib_reg, bus.bus_wire[7:4]};
   assign take    = bus.strobe && (width8_out || nibble_hi_reg);
   assign is_read = bus.rd_wr;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         nibble_hi_reg <= 1'b0;
         nib_reg       <= 4'h0;
      end
      else if (bus.strobe && !width8_out)
      begin
         nibble_hi_reg <= !nibble_hi_reg;
         nib_reg       <= bus.bus_wire[7:4];
      end
   end

   // ==========================================================================
   // Busy indicator
   // ==========================================================================
   assign rs_wr_take = take && !(is_read && !bus.reg_select);
   assign busy_indicator = (state_reg == CLRA_EXEC);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg    <= CLRA_IDLE;
         exec_cnt_reg <= 16'h0000;
      end
      else
      begin
         unique case (state_reg)
            CLRA_IDLE:
               if (rs_wr_take)
               begin
                  state_reg    <= CLRA_EXEC;
                  exec_cnt_reg <= 16'(EXEC_CYCLES);
               end
            CLRA_EXEC:
               if (exec_cnt_reg <= 16'h0001)
                  state_reg <= CLRA_IDLE;
               else
                  exec_cnt_reg <= exec_cnt_reg - 16'h0001;
            default:
               state_reg <= CLRA_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Instruction and data execution
   // ==========================================================================
   clra_addr_step u_step (
      .addr_in     (addr_counter_reg),
      .inc_in      (inc_reg),
      .glyph_in    (glyph_sel_out),
      .two_line_in (two_line_out),
      .addr_out    (addr_step)
   );

   // Cursor shifts step by their own direction bit, not by the entry mode.
   clra_addr_step u_shift (
      .addr_in     (addr_counter_reg),
      .inc_in      (byte_in[BIT_RL]),
      .glyph_in    (glyph_sel_out),
      .two_line_in (two_line_out),
      .addr_out    (shift_step)
   );

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         addr_counter_reg <= 7'h00;
         glyph_sel_out    <= 1'b0;
         inc_reg          <= RST_INC;
         two_line_out     <= RST_TWO_LINE;
         font_big_out     <= RST_FONT_BIG;
         width8_out       <= RST_WIDTH8;
         out_data_reg     <= 8'h00;
      end
      else if (take && !bus.reg_select && !is_read)
      begin
         if (byte_in[BIT_DDR_SET])
         begin
            addr_counter_reg <= byte_in[6:0];
            glyph_sel_out    <= 1'b0;
            out_data_reg     <= display_ram[byte_in[6:0]];
         end
         else if (byte_in[BIT_CGR_SET])
         begin
            addr_counter_reg <= byte_in[6:0] & CG_MASK;
            glyph_sel_out    <= 1'b1;
            out_data_reg     <= glyph_ram[byte_in[5:0]];
         end
         else if (byte_in[BIT_FUNC])
         begin
            width8_out   <= byte_in[BIT_WIDTH];
            two_line_out <= byte_in[BIT_LINES];
            font_big_out <= byte_in[BIT_FONT];
         end
         else if (byte_in[BIT_SHIFT])
         begin
            if (!byte_in[BIT_SC] && !glyph_sel_out)
            begin
               addr_counter_reg <= shift_step;
               out_data_reg     <= display_ram[shift_step];
            end
         end
         // Display on/off control shares the low bits and is ignored here.
         else if (byte_in[BIT_ENTRY] && !byte_in[BIT_DISP])
            inc_reg <= byte_in[BIT_INCDEC];
         else if (!byte_in[BIT_DISP]
                  && (byte_in[BIT_HOME] || byte_in[BIT_CLEAR]))
         begin
            addr_counter_reg <= 7'h00;
            glyph_sel_out    <= 1'b0;
            if (byte_in[BIT_CLEAR])
               inc_reg <= 1'b1;
         end
      end
      else if (take && bus.reg_select)
      begin
         addr_counter_reg <= addr_step;
         if (is_read)
            out_data_reg <= glyph_sel_out ? glyph_ram[addr_step[5:0]]
                                          : display_ram[addr_step];
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (take && bus.reg_select && !is_read)
      begin
         if (glyph_sel_out)
            glyph_ram[addr_counter_reg[5:0]] <= byte_in;
         else
            display_ram[addr_counter_reg] <= byte_in;
      end
   end

   // ==========================================================================
   // Read path
   // ==========================================================================
   always_comb
   begin
      logic [7:0] word;
      word = bus.reg_select ? out_data_reg
                            : {busy_indicator, addr_counter_reg};
      bus.bus_dev_oe = bus.rd_wr;
      if (width8_out || !nibble_hi_reg)
         bus.bus_dev = width8_out ? word : {word[7:4], 4'h0};
      else
         bus.bus_dev = {word[3:0], 4'h0};
   end
endmodule : clra_device
`default_nettype wire

// >>> clra_host.sv
// Host end: runs one bus cycle per command in eight-bit mode and two in four-bit mode, and polls busy before each command, reads included.
`timescale 1ns/1ps
`default_nettype none
module clra_host
   import clra_pkg::*;
(
   input  wire logic       clk_in,      // 25 MHz clock.
   input  wire logic       rst_n_in,    // Asynchronous reset, active low.
   clra_if.host            bus,         // Device bus.
   input  wire logic       cmd_in,      // One-cycle request pulse.
   input  wire logic       cmd_rs_in,   // Register select of the request.
   input  wire logic       cmd_rd_in,   // High for a read.
   input  wire logic [7:0] cmd_data_in, // Write byte.
   input  wire logic       width8_in,   // Device is in eight-bit mode.
   output logic            ready_out,   // Host accepts a request.
   output logic            done_out,    // Request finished, one cycle.
   output logic      [7:0] rdata_out    // Read byte.
);
   typedef enum logic [3:0] {
      CLRA_H_IDLE = 4'b0001,
      CLRA_H_POLL = 4'b0010,
      CLRA_H_XFER = 4'b0100,
      CLRA_H_DONE = 4'b1000
   } clra_host_state_e;

   clra_host_state_e state_reg;
   logic       rs_reg;
   logic       rd_reg;
   logic [7:0] data_reg;
   logic       half_reg;
   logic       poll_half_reg;
   logic       poll_busy_reg;

   assign ready_out        = (state_reg == CLRA_H_IDLE);
   assign bus.reg_select   = (state_reg == CLRA_H_POLL) ? 1'b0 : rs_reg;
   assign bus.rd_wr        = (state_reg == CLRA_H_POLL) ? 1'b1 : rd_reg;
   assign bus.bus_host_oe  = (state_reg == CLRA_H_XFER) && !rd_reg;
   assign bus.bus_host     = (width8_in || half_reg) ? data_reg
                                                     : {data_reg[3:0], 4'h0};
   assign bus.strobe       = (state_reg == CLRA_H_POLL)
                          || (state_reg == CLRA_H_XFER);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg     <= CLRA_H_IDLE;
         rs_reg        <= 1'b0;
         rd_reg        <= 1'b0;
         data_reg      <= 8'h00;
         half_reg      <= 1'b1;
         poll_half_reg <= 1'b1;
         poll_busy_reg <= 1'b0;
         done_out      <= 1'b0;
         rdata_out     <= 8'h00;
      end
      else
      begin
         done_out <= 1'b0;
         unique case (state_reg)
            CLRA_H_IDLE:
               if (cmd_in)
               begin
                  rs_reg        <= cmd_rs_in;
                  rd_reg        <= cmd_rd_in;
                  data_reg      <= cmd_data_in;
                  half_reg      <= 1'b1;
                  poll_half_reg <= 1'b1;
                  state_reg     <= CLRA_H_POLL;
               end
            CLRA_H_POLL:
            begin
               if (width8_in || poll_half_reg)
                  poll_busy_reg <= bus.bus_wire[BIT_BUSY];
               if (!width8_in && poll_half_reg)
                  poll_half_reg <= 1'b0;
               else
               begin
                  poll_half_reg <= 1'b1;
                  if (!(width8_in ? bus.bus_wire[BIT_BUSY] : poll_busy_reg))
                     state_reg <= CLRA_H_XFER;
               end
            end
            CLRA_H_XFER:
            begin
               if (rd_reg)
               begin
                  if (width8_in)
                     rdata_out <= bus.bus_wire;
                  else if (half_reg)
                     rdata_out[7:4] <= bus.bus_wire[7:4];
                  else
                     rdata_out[3:0] <= bus.bus_wire[7:4];
               end
               if (!width8_in && half_reg)
                  half_reg <= 1'b0;
               else
                  state_reg <= CLRA_H_DONE;
            end
            CLRA_H_DONE:
            begin
               done_out  <= 1'b1;
               state_reg <= CLRA_H_IDLE;
            end
            default:
               state_reg <= CLRA_H_IDLE;
         endcase
      end
   end
endmodule : clra_host
`default_nettype wire

// >>> clra_checker.sv
// Concurrent checks on the host bus joining the two ends.
`timescale 1ns/1ps
`default_nettype none
module clra_checker
(
   input  wire logic       clk_in,      // Bus clock.
   input  wire logic       rst_n_in,    // Asynchronous reset, active low.
   input  wire logic       reg_select,  // Instruction or data select.
   input  wire logic       rd_wr,       // High reads.
   input  wire logic       strobe,      // Transfer pulse.
   input  wire logic       bus_host_oe, // Host drives the bus.
   input  wire logic       bus_dev_oe,  // Device drives the bus.
   input  wire logic [7:0] bus_wire,    // Resolved bus.
   input  wire logic       width8_out   // Device in eight-bit mode.
);
   logic       stat_rd;
   logic       nonstat;
   logic       poll_ok_reg;
   logic       ac_known_reg;
   logic [6:0] ac_val_reg;

   assign stat_rd = strobe && !reg_select && rd_wr;
   assign nonstat = strobe && !stat_rd && width8_out;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // ==============================
   // Helper state
   // ==============================
   // Remembers whether the last cycle was an eight-bit-mode poll that found the device idle.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         poll_ok_reg <= 1'b0;
      else
         poll_ok_reg <= stat_rd && !bus_wire[7] && width8_out;
   end

   // Follows the counter only after reset or while an eight-bit-mode address set was the last access.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ac_known_reg <= 1'b1;
         ac_val_reg   <= 7'h00;
      end
      else if (nonstat && !reg_select && bus_wire[7])
      begin
         ac_known_reg <= 1'b1;
         ac_val_reg   <= bus_wire[6:0];
      end
      else if (nonstat && !reg_select && bus_wire[6])
      begin
         ac_known_reg <= 1'b1;
         ac_val_reg   <= {1'b0, bus_wire[5:0]};
      end
      else if (strobe && !stat_rd)
         ac_known_reg <= 1'b0;
   end

   // ==============================
   // Assertions
   // ==============================
   no_bus_fight_a:
      assert property (!(bus_host_oe && bus_dev_oe))
      else $error("Both ends drive the bus.");
   read_drive_a:
      assert property (strobe && rd_wr |-> bus_dev_oe && !bus_host_oe)
      else $error("Device does not drive a read.");
   write_drive_a:
      assert property (strobe && !rd_wr |-> bus_host_oe && !bus_dev_oe)
      else $error("Host does not drive a write.");
   busy_hold_a:
      assert property (nonstat |=> (!(stat_rd && width8_out) || bus_wire[7])[*5])
      else $error("Busy dropped too early.");
   busy_end_a:
      assert property (nonstat |-> ##6 !(stat_rd && width8_out && bus_wire[7]))
      else $error("Busy held too long.");
   host_waits_a:
      assert property (stat_rd && width8_out && bus_wire[7] |=> !strobe || stat_rd)
      else $error("Host issued an access while busy.");
   poll_first_a:
      assert property (nonstat |-> poll_ok_reg)
      else $error("Access not preceded by an idle poll.");
   status_addr_a:
      assert property (stat_rd && width8_out && ac_known_reg
                       |-> bus_wire[6:0] == ac_val_reg)
      else $error("Status read shows wrong counter.");
endmodule : clra_checker
`default_nettype wire

// >>> test_char_lcd_ram_access_cmds.sv
// Testbench joining the host and device ends over the parallel bus.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module test_char_lcd_ram_access_cmds;
   logic       clk_in      = 1'b0;
   logic       rst_n_in    = 1'b0;
   logic       cmd_in      = 1'b0;
   logic       cmd_rs_in   = 1'b0;
   logic       cmd_rd_in   = 1'b0;
   logic [7:0] cmd_data_in = 8'h00;
   logic [7:0] wr_hist     = 8'h00;
   logic       ready_out, done_out, width8_out;
   logic       two_line_out, font_big_out, glyph_sel_out;
   logic [7:0] rdata_out;
   int         errors  = 0;
   int         n_tests = 0;
   int         cycles  = 0;

   always #20 clk_in = ~clk_in;

   clra_if u_clra_if ();
   clra_device #(.EXEC_CYCLES(5)) u_clra_device (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .bus(u_clra_if.dev), .two_line_out(two_line_out),
      .font_big_out(font_big_out), .width8_out(width8_out),
      .glyph_sel_out(glyph_sel_out));
   clra_host u_clra_host (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .bus(u_clra_if.host), .cmd_in(cmd_in), .cmd_rs_in(cmd_rs_in),
      .cmd_rd_in(cmd_rd_in), .cmd_data_in(cmd_data_in),
      .width8_in(width8_out), .ready_out(ready_out), .done_out(done_out),
      .rdata_out(rdata_out));
   clra_checker u_clra_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .reg_select(u_clra_if.reg_select), .rd_wr(u_clra_if.rd_wr),
      .strobe(u_clra_if.strobe), .bus_host_oe(u_clra_if.bus_host_oe),
      .bus_dev_oe(u_clra_if.bus_dev_oe), .bus_wire(u_clra_if.bus_wire),
      .width8_out(width8_out));

   // Collects the nibbles of write transfers as they appear on the wire.
   always @(posedge clk_in)
   begin
      if (u_clra_if.strobe && !u_clra_if.rd_wr)
         wr_hist <= {wr_hist[3:0], u_clra_if.bus_wire[7:4]};
   end

   // ==============================
   // Shared tasks
   // ==============================
   task automatic stop_test;
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errors++;
         stop_test();
      end
   end

   task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
                       output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      cmd_in      <= 1'b1;
      cmd_rs_in   <= rs;
      cmd_rd_in   <= rd;
      cmd_data_in <= d;
      @(posedge clk_in);
      cmd_in <= 1'b0;
      while (done_out !== 1'b1 && n < 100)
      begin
         @(negedge clk_in);
         n++;
      end
      q = rdata_out;
      `CHK(ready_out, 1'b1)
      if (n == 100)
         `CHK(done_out, 1'b1)
   endtask : xfer

   task automatic wr(input logic rs, input logic [7:0] d);
      logic [7:0] q;
      xfer(rs, 1'b0, d, q);
   endtask : wr

   task automatic rd(input logic rs, input logic [7:0] e);
      logic [7:0] q;
      xfer(rs, 1'b1, 8'h00, q);
      `CHK(q, e)
   endtask : rd

   // ==============================
   // Scenarios
   // ==============================
   task automatic t_reset;
      rd(1'b0, 8'h00);
      `CHK({two_line_out, font_big_out, width8_out, glyph_sel_out}, 4'b0010)
   endtask : t_reset

   task automatic t_func;
      for (int i = 0; i < 4; i++)
      begin
         wr(1'b0, {4'h3, i[1:0], 2'b00});
         `CHK(two_line_out, i[1])
         `CHK(font_big_out, i[0])
      end
      wr(1'b0, 8'h30);
   endtask : t_func

   task automatic t_display_ram;
      wr(1'b0, 8'h85);
      rd(1'b0, 8'h05);
      `CHK(glyph_sel_out, 1'b0)
      wr(1'b1, 8'h41);
      wr(1'b1, 8'h42);
      wr(1'b1, 8'h43);
      rd(1'b0, 8'h08);
      wr(1'b0, 8'h85);
      rd(1'b1, 8'h41);
      rd(1'b1, 8'h42);
      rd(1'b0, 8'h07);
      wr(1'b1, 8'h55);
      rd(1'b1, 8'h43);
      wr(1'b0, 8'h87);
      rd(1'b1, 8'h55);
   endtask : t_display_ram

   task automatic t_glyph;
      wr(1'b0, 8'h7f);
      `CHK(glyph_sel_out, 1'b1)
      rd(1'b0, 8'h3f);
      wr(1'b1, 8'ha5);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'h7f);
      rd(1'b1, 8'ha5);
      wr(1'b0, 8'h85);
      rd(1'b1, 8'h41);
   endtask : t_glyph

   task automatic t_lines;
      wr(1'b0, 8'ha7);
      wr(1'b1, 8'h20);
      rd(1'b0, 8'h28);
      wr(1'b0, 8'hcf);
      wr(1'b1, 8'h20);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'h38);
      wr(1'b0, 8'ha7);
      wr(1'b1, 8'h20);
      rd(1'b0, 8'h40);
      wr(1'b0, 8'he7);
      wr(1'b1, 8'h20);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'h30);
   endtask : t_lines

   task automatic t_entry;
      wr(1'b0, 8'h04);
      wr(1'b0, 8'h85);
      wr(1'b1, 8'h66);
      rd(1'b0, 8'h04);
      wr(1'b0, 8'h06);
      wr(1'b0, 8'h0d);
      wr(1'b0, 8'h85);
      wr(1'b1, 8'h41);
      rd(1'b0, 8'h06);
   endtask : t_entry

   task automatic t_cursor;
      wr(1'b0, 8'h85);
      wr(1'b0, 8'h14);
      rd(1'b0, 8'h06);
      rd(1'b1, 8'h42);
      wr(1'b0, 8'h10);
      rd(1'b0, 8'h06);
      rd(1'b1, 8'h42);
      wr(1'b0, 8'h02);
      rd(1'b0, 8'h00);
   endtask : t_cursor

   task automatic t_nibble;
      wr(1'b0, 8'h20);
      `CHK(width8_out, 1'b0)
      wr(1'b0, 8'h8a);
      wr(1'b1, 8'h3c);
      `CHK(wr_hist, 8'h3c)
      wr(1'b0, 8'h8a);
      rd(1'b1, 8'h3c);
      rd(1'b0, 8'h0b);
      wr(1'b0, 8'h30);
      `CHK(width8_out, 1'b1)
   endtask : t_nibble

   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_func();
      t_display_ram();
      t_glyph();
      t_lines();
      t_entry();
      t_cursor();
      t_nibble();
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      stop_test();
   end
endmodule : test_char_lcd_ram_access_cmds
`default_nettype wire
